// file: inc/icf_pkg.sv
/*
  Constants for the interrupt control and request flag register block:
  register byte offsets, field positions, implemented-bit masks, reset
  values.
  Assumes a 32-bit Avalon-MM slave port with 16-bit registers placed in
  the low half of each aligned word.
*/
package icf_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam int          ADDR_W           = 6;
  localparam logic [5:0]  OFF_CORE_PRIO    = 6'h00;
  localparam logic [5:0]  OFF_ALU_STATUS   = 6'h04;
  localparam logic [5:0]  OFF_CTRL_ONE     = 6'h08;
  localparam logic [5:0]  OFF_CTRL_TWO     = 6'h0C;
  localparam logic [5:0]  OFF_FLAGS_BASE   = 6'h10;
  localparam logic [5:0]  OFF_ENABLE_BASE  = 6'h1C;
  localparam logic [5:0]  OFF_SRC_PRIO     = 6'h28;
  localparam logic [5:0]  OFF_IRQ_STATUS   = 6'h2C;
  localparam logic [5:0]  OFF_IRQ_MASK     = 6'h30;
  localparam logic [5:0]  WORD_STRIDE      = 6'h04;
  localparam int          NUM_WORDS        = 3;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int          POS_LEVEL_EXT    = 3;
  localparam int          POS_RESERVED_ONE = 2;
  localparam int          POS_STATUS_PRIO  = 5;
  localparam int          POS_NEST_DIS     = 15;
  localparam int          POS_ARITH_TRAP   = 4;
  localparam int          POS_ADDR_TRAP    = 3;
  localparam int          POS_STACK_TRAP   = 2;
  localparam int          POS_OSC_TRAP     = 1;
  localparam int          POS_ALT_TABLE    = 15;
  localparam int          POS_DISABLE_INSN = 14;
  localparam int          POS_EXT0_FLAG    = 0;
  localparam int          POS_EXT1_FLAG    = 4;
  localparam int          POS_EXT2_FLAG    = 13;
  localparam int          POS_IRQ_REQ      = 0;
  localparam int          POS_IRQ_TRAP     = 1;
  localparam int          POS_IRQ_EDGE     = 2;
  localparam int          SRC_PRIO_STRIDE  = 4;

  // ------------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] MASK_CTRL_ONE    = 16'h801E;
  localparam logic [15:0] MASK_CTRL_TWO_WR = 16'h801F;
  localparam logic [15:0] MASK_FLAGS0      = 16'h3FEF;
  localparam logic [15:0] MASK_FLAGS1      = 16'hFEDF;
  localparam logic [15:0] MASK_FLAGS2      = 16'h3FE3;
  localparam logic [15:0] MASK_SRC_PRIO    = 16'h0777;
  localparam logic [2:0]  MASK_IRQ         = 3'h7;
  localparam logic [15:0] RESET_REG16      = 16'h0000;
  localparam logic [2:0]  STATUS_PRIO_MAX  = 3'h7;
  localparam logic [2:0]  RESET_IRQ        = 3'h0;
  localparam int          NUM_EXT          = 5;

endpackage

// file: src/icf_regs.sv
/*
  Interrupt control and request flag registers: CPU priority level with
  its extension bit, nesting disable, trap flags, vector table select,
  external edge polarity, three request flag words with enables and a
  per-word source priority, CPU request generation and a maskable
  summary interrupt.
  Assumes all inputs synchronous to mclk and an Avalon-MM master that
  holds its request until waitrequest is sampled low.
*/
// Local design decisions: the Avalon-MM slave port and the placing of the registers.

// Behaviour
// (R1) CPU priority is four bits: extension bit on top, status bits below.
// (R2) With nesting disabled, software writes to status priority bits are ignored.
// (R3) Extension bit: set/cleared by hardware, software may only clear it.
// (R4) Core register bit 2 reads 1; every other unused bit reads 0.
// (R5) Nesting disable is read/write at control one bit 15, resets 0.
// (R6) Trap flags at control one bits 4..1, hardware set, software R/W.
// (R7) Control two bit 15 selects the alternate vector table, resets 0.
// (R8) Control two bits 4..0 pick negative (1) or positive (0) edges.
// (R9) Request flags are set by their source, software R/W, reset 0.
// (R10) Flag word 0 holds its sources at bits 13..0, bit 4 unused.
// (R11) Flag word 1 holds its sources at bits 15..0, bits 8 and 5 unused.
// (R12) Flag word 2 holds sources at bits 13..5 and 1..0.
// (R13) Unimplemented bits ignore writes and read zero.
// (R14) Status priority of 7 blocks every user interrupt.
// (R15) Sources set flags; only software clears them.
// (R16) CPU request needs flag, enable and source priority above CPU level.
module icf_regs
  import icf_pkg::*;
(
  input  wire logic                   mclk,             // System clock
  input  wire logic                   rst_n,            // Async reset
  input  wire logic [icf_pkg::ADDR_W-1:0] avsAddress,   // Byte address
  input  wire logic                   avsRead,          // Read request
  input  wire logic                   avsWrite,         // Write request
  input  wire logic [31:0]            avsWriteData,     // Write data
  input  wire logic [3:0]             avsByteEnable,    // Byte lanes
  output logic      [31:0]            avsReadData,      // Read data
  output logic                        avsWaitRequest,   // Stall
  input  wire logic [15:0]            srcReq0,          // Word 0 sources
  input  wire logic [15:0]            srcReq1,          // Word 1 sources
  input  wire logic [15:0]            srcReq2,          // Word 2 sources
  input  wire logic [icf_pkg::NUM_EXT-1:0] extPin,      // External pins
  input  wire logic                   trapArith,        // Overflow trap
  input  wire logic                   trapAddr,         // Address trap
  input  wire logic                   trapStack,        // Stack trap
  input  wire logic                   trapOsc,          // Osc fail trap
  input  wire logic                   cpuPrioLoad,      // Core sets level
  input  wire logic [3:0]             cpuPrioValue,     // New level
  input  wire logic                   disableInsnActive, // Disable insn
  output logic      [3:0]             cpuPriority,      // Current level
  output logic                        nestingDisable,   // Nesting off
  output logic                        altTableSelect,   // Alt vectors
  output logic      [icf_pkg::NUM_EXT-1:0] extEdgeEvent, // Edge pulses
  output logic                        cpuRequest,       // Request to CPU
  output logic                        irqOut            // Summary irq
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [15:0] mergeWrite(input logic [15:0] old,
                                             input logic [15:0] data,
                                             input logic [15:0] lanes,
                                             input logic [15:0] impl);
    logic [15:0] m;
    m          = lanes & impl;
    mergeWrite = ((old & ~m) | (data & m)) & impl;
  endfunction

  localparam logic [15:0] FLAG_IMPL [NUM_WORDS] =
    '{MASK_FLAGS0, MASK_FLAGS1, MASK_FLAGS2};  // R10 R11 R12

  logic              waitFf;
  logic [31:0]       readDataFf;

  logic              takeWrite;
  logic              takeRead;

  logic [15:0]       wrLanes;
  logic [15:0]       wrData;

  logic [31:0]       readMux;

  logic [2:0]        statusPrioFf;
  logic              levelExtFf;
  logic [15:0]       ctrlOneFf;
  logic [15:0]       ctrlTwoFf;

  logic [15:0]       srcPrioFf;
  logic [2:0]        irqStatusFf;
  logic [2:0]        irqMaskFf;

  logic              irqFf;
  logic              cpuReqFf;

  logic [NUM_EXT-1:0] extPrevFf;
  logic [NUM_EXT-1:0] extEdgeFf;
  logic [NUM_EXT-1:0] edgeNow;

  logic [15:0]       flagFf    [NUM_WORDS];
  logic [15:0]       enableFf  [NUM_WORDS];

  logic [15:0]       flagSet   [NUM_WORDS];
  logic [NUM_WORDS-1:0] wordPending;
  logic [NUM_WORDS-1:0] wordNewSet;

  logic [15:0]       trapSet;

  assign takeWrite = avsWrite && !waitFf;
  assign takeRead  = avsRead && !waitFf;

  assign wrLanes   = laneMask(avsByteEnable);
  assign wrData    = avsWriteData[15:0];

  assign avsWaitRequest = waitFf;
  assign avsReadData    = readDataFf;
  assign cpuPriority    = {levelExtFf, statusPrioFf};                 // R1
  assign nestingDisable = ctrlOneFf[POS_NEST_DIS];

  assign altTableSelect = ctrlTwoFf[POS_ALT_TABLE];

  assign extEdgeEvent   = extEdgeFf;
  assign cpuRequest     = cpuReqFf;
  assign irqOut         = irqFf;

  // ------------------------------------------------------------------
  // Avalon slave handshake: one wait cycle, then the answer
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waitFf <= 1'b1;
    end else if ((avsRead || avsWrite) && waitFf) begin
      waitFf <= 1'b0;
    end else begin
      waitFf <= 1'b1;
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (avsAddress)
      OFF_CORE_PRIO: begin
        readMux[POS_LEVEL_EXT]    = levelExtFf;                       // R4
        readMux[POS_RESERVED_ONE] = 1'b1;                             // R4
      end
      OFF_ALU_STATUS: begin
        readMux[POS_STATUS_PRIO +: 3] = statusPrioFf;
      end
      OFF_CTRL_ONE: begin
        readMux[15:0] = ctrlOneFf & MASK_CTRL_ONE;                    // R13
      end
      OFF_CTRL_TWO: begin
        readMux[15:0] = ctrlTwoFf & MASK_CTRL_TWO_WR;
        readMux[POS_DISABLE_INSN] = disableInsnActive;
      end

      OFF_SRC_PRIO: begin
        readMux[15:0] = srcPrioFf;
      end

      OFF_IRQ_STATUS: begin
        readMux[2:0] = irqStatusFf;
      end
      OFF_IRQ_MASK: begin
        readMux[2:0] = irqMaskFf;
      end

      default: begin
        for (int w = 0; w < NUM_WORDS; w++) begin
          if (avsAddress == OFF_FLAGS_BASE + ADDR_W'(w) * WORD_STRIDE) begin
            readMux[15:0] = flagFf[w];
          end
          if (avsAddress == OFF_ENABLE_BASE + ADDR_W'(w) * WORD_STRIDE) begin
            readMux[15:0] = enableFf[w];
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readDataFf <= 32'h0000_0000;
    end else if (avsRead && waitFf) begin
      readDataFf <= readMux;
    end
  end

  // ------------------------------------------------------------------
  // CPU priority level
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      statusPrioFf <= 3'h0;
    end else if (cpuPrioLoad) begin
      statusPrioFf <= cpuPrioValue[2:0];
    end else if (takeWrite && avsAddress == OFF_ALU_STATUS &&
                 avsByteEnable[0] && !ctrlOneFf[POS_NEST_DIS]) begin // R2
      statusPrioFf <= wrData[POS_STATUS_PRIO +: 3];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      levelExtFf <= 1'b0;                                             // R3
    end else if (cpuPrioLoad) begin
      levelExtFf <= cpuPrioValue[3];                                  // R3
    end else if (takeWrite && avsAddress == OFF_CORE_PRIO &&
                 avsByteEnable[0] && !wrData[POS_LEVEL_EXT]) begin
      levelExtFf <= 1'b0;                                             // R3
    end
  end

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------
  always_comb begin
    trapSet                 = 16'h0000;
    trapSet[POS_ARITH_TRAP] = trapArith;
    trapSet[POS_ADDR_TRAP]  = trapAddr;
    trapSet[POS_STACK_TRAP] = trapStack;
    trapSet[POS_OSC_TRAP]   = trapOsc;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlOneFf <= RESET_REG16;                                       // R5
    end else if (takeWrite && avsAddress == OFF_CTRL_ONE) begin
      ctrlOneFf <= mergeWrite(ctrlOneFf, wrData, wrLanes,
                              MASK_CTRL_ONE) | trapSet;               // R6
    end else begin
      ctrlOneFf <= ctrlOneFf | trapSet;                               // R6
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlTwoFf <= RESET_REG16;                                       // R7
    end else if (takeWrite && avsAddress == OFF_CTRL_TWO) begin
      ctrlTwoFf <= mergeWrite(ctrlTwoFf, wrData, wrLanes,
                              MASK_CTRL_TWO_WR);                      // R8
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      srcPrioFf <= RESET_REG16;
    end else if (takeWrite && avsAddress == OFF_SRC_PRIO) begin
      srcPrioFf <= mergeWrite(srcPrioFf, wrData, wrLanes, MASK_SRC_PRIO);
    end
  end

  // ------------------------------------------------------------------
  // External edge detection
  // ------------------------------------------------------------------
  assign edgeNow = (ctrlTwoFf[NUM_EXT-1:0] & extPrevFf & ~extPin) |
                   (~ctrlTwoFf[NUM_EXT-1:0] & ~extPrevFf & extPin); // R8

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      extPrevFf <= '0;
      extEdgeFf <= '0;
    end else begin
      extPrevFf <= extPin;
      extEdgeFf <= edgeNow;
    end
  end

  // ------------------------------------------------------------------
  // Request flag words, enables and pending detection
  // ------------------------------------------------------------------
  always_comb begin
    flagSet[0] = srcReq0;
    flagSet[1] = srcReq1;
    flagSet[2] = srcReq2;
    flagSet[0][POS_EXT0_FLAG] = srcReq0[POS_EXT0_FLAG] | edgeNow[0];
    flagSet[1][POS_EXT1_FLAG] = srcReq1[POS_EXT1_FLAG] | edgeNow[1];
    flagSet[1][POS_EXT2_FLAG] = srcReq1[POS_EXT2_FLAG] | edgeNow[2];
  end

  generate
    for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
      localparam logic [5:0] FLAG_OFF =
        OFF_FLAGS_BASE + 6'(w * 4);
      localparam logic [5:0] EN_OFF =
        OFF_ENABLE_BASE + 6'(w * 4);
      logic [15:0] setMasked;
      logic [2:0]  wordPrio;

      assign setMasked = flagSet[w] & FLAG_IMPL[w];                   // R13
      assign wordPrio  = srcPrioFf[w * SRC_PRIO_STRIDE +: 3];

      assign wordNewSet[w] = |(setMasked & ~flagFf[w]);
      assign wordPending[w] = |(flagFf[w] & enableFf[w]) &&
                              ({1'b0, wordPrio} > cpuPriority);       // R16

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          flagFf[w] <= RESET_REG16;                                   // R9
        end else if (takeWrite && avsAddress == FLAG_OFF) begin
          flagFf[w] <= mergeWrite(flagFf[w], wrData, wrLanes,
                                  FLAG_IMPL[w]) | setMasked;          // R15
        end else begin
          flagFf[w] <= flagFf[w] | setMasked;                         // R9
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          enableFf[w] <= RESET_REG16;
        end else if (takeWrite && avsAddress == EN_OFF) begin
          enableFf[w] <= mergeWrite(enableFf[w], wrData, wrLanes,
                                    FLAG_IMPL[w]);
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpuReqFf <= 1'b0;
    end else begin
      cpuReqFf <= (|wordPending) &&
                  (statusPrioFf != STATUS_PRIO_MAX);                  // R14
    end
  end

  // ------------------------------------------------------------------
  // Summary interrupt: sticky status, read-to-clear, mask
  // ------------------------------------------------------------------

  logic [2:0] irqEvent;

  always_comb begin
    irqEvent               = 3'h0;
    irqEvent[POS_IRQ_REQ]  = |wordNewSet;
    irqEvent[POS_IRQ_TRAP] = |trapSet;
    irqEvent[POS_IRQ_EDGE] = |edgeNow;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatusFf <= RESET_IRQ;
    end else if (takeRead && avsAddress == OFF_IRQ_STATUS) begin
      irqStatusFf <= irqEvent;
    end else begin
      irqStatusFf <= irqStatusFf | irqEvent;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqMaskFf <= RESET_IRQ;
    end else if (takeWrite && avsAddress == OFF_IRQ_MASK &&
                 avsByteEnable[0]) begin
      irqMaskFf <= wrData[2:0] & MASK_IRQ;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqFf <= 1'b0;
    end else begin
      irqFf <= |(irqStatusFf & irqMaskFf);
    end
  end

endmodule

// file: tb/icf_chk.sv
/*
  Port checker of the interrupt control and request flag registers.
  Assumes a bind to icf_regs, one clock and an async active-low reset.
*/
module icf_chk
  import icf_pkg::*;
(
  input logic                        mclk,           // Clock
  input logic                        rst_n,          // Reset
  input logic [icf_pkg::ADDR_W-1:0]  avsAddress,     // Address
  input logic                        avsRead,        // Read
  input logic                        avsWrite,       // Write
  input logic [31:0]                 avsReadData,    // Read data
  input logic                        avsWaitRequest, // Stall
  input logic                        cpuPrioLoad,    // Level load
  input logic [3:0]                  cpuPrioValue,   // Loaded level
  input logic [3:0]                  cpuPriority,    // Level
  input logic                        nestingDisable, // Nesting off
  input logic                        altTableSelect, // Alt vectors
  input logic                        cpuRequest      // CPU request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic        rdAns;
  logic        wrAns;
  logic [15:0] flagMask;
  assign rdAns = avsRead && !avsWaitRequest;
  assign wrAns = avsWrite && !avsWaitRequest;
  assign flagMask = (avsAddress == OFF_FLAGS_BASE) ? MASK_FLAGS0 :
                    (avsAddress == OFF_FLAGS_BASE + WORD_STRIDE) ?
                    MASK_FLAGS1 : MASK_FLAGS2;

  chk_wait_single: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
  chk_wait_answer: assert property ((avsRead || avsWrite) && avsWaitRequest
    |=> !avsWaitRequest) else $error("request not answered");
  chk_core_read: assert property (rdAns && avsAddress == OFF_CORE_PRIO
    |-> avsReadData[15:0] == {12'h000, $past(cpuPriority[3]), 3'h4})
    else $error("core register read wrong");
  chk_ctrl_read: assert property (rdAns && avsAddress == OFF_CTRL_ONE
    |-> (avsReadData[15:0] & ~MASK_CTRL_ONE) == 16'h0000
    && avsReadData[15] == $past(nestingDisable))
    else $error("control one read wrong");
  chk_flag_holes: assert property (rdAns && avsAddress >= OFF_FLAGS_BASE
    && avsAddress < OFF_ENABLE_BASE
    |-> (avsReadData[15:0] & ~flagMask) == 16'h0000)
    else $error("unimplemented flag bit read one");
  chk_prio_locked: assert property (wrAns && nestingDisable
    && avsAddress == OFF_ALU_STATUS && !cpuPrioLoad
    |=> cpuPriority[2:0] == $past(cpuPriority[2:0]))
    else $error("status priority written while locked");
  chk_ext_noset: assert property (!cpuPriority[3] && !cpuPrioLoad
    |=> !cpuPriority[3]) else $error("extension bit set by software");
  chk_prio_load: assert property (cpuPrioLoad
    |=> cpuPriority == $past(cpuPrioValue)) else $error("level not loaded");
  chk_nest_hold: assert property (!(wrAns && avsAddress == OFF_CTRL_ONE)
    |=> $stable(nestingDisable)) else $error("nesting bit changed alone");
  chk_alt_hold: assert property (!(wrAns && avsAddress == OFF_CTRL_TWO)
    |=> $stable(altTableSelect)) else $error("table select changed alone");
  chk_top_block: assert property (cpuPriority[2:0] == STATUS_PRIO_MAX
    |=> !cpuRequest) else $error("request at top priority");
endmodule

bind icf_regs icf_chk u_icf_chk (.mclk, .rst_n, .avsAddress, .avsRead,
  .avsWrite, .avsReadData, .avsWaitRequest, .cpuPrioLoad, .cpuPrioValue,
  .cpuPriority, .nestingDisable, .altTableSelect, .cpuRequest);

// file: tb/icf_src_model.sv
/*
  Model of the CPU core and the peripheral request sources.
  Assumes the bench calls its tasks; outputs move right after mclk rises.
*/
module icf_src_model
  import icf_pkg::*;
(
  input  wire logic                  mclk,              // Clock
  output logic [15:0]                srcReq0,           // Word 0 sources
  output logic [15:0]                srcReq1,           // Word 1 sources
  output logic [15:0]                srcReq2,           // Word 2 sources
  output logic [icf_pkg::NUM_EXT-1:0] extPin,           // Pins
  output logic                       trapArith,         // Overflow
  output logic                       trapAddr,          // Address
  output logic                       trapStack,         // Stack
  output logic                       trapOsc,           // Osc fail
  output logic                       cpuPrioLoad,       // Level load
  output logic [3:0]                 cpuPrioValue,      // Level
  output logic                       disableInsnActive  // Disable insn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] reqWord [3];
  logic [3:0]  trapVec;
  assign srcReq0 = reqWord[0];
  assign srcReq1 = reqWord[1];
  assign srcReq2 = reqWord[2];
  assign {trapArith, trapAddr, trapStack, trapOsc} = trapVec;
  initial begin
    reqWord = '{default: 16'h0000};
    trapVec = 4'h0;
    extPin = 5'h00;
    cpuPrioLoad = 1'b0;
    cpuPrioValue = 4'h0;
    disableInsnActive = 1'b0;
  end
  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask
  // Sources only raise requests; software clears
  task automatic pulse_src(input int w, input logic [15:0] m);
    @(posedge mclk);
    reqWord[w] <= m;
    @(posedge mclk);
    reqWord[w] <= 16'h0000;
    settle();
  endtask
  task automatic pulse_trap(input logic [3:0] m);
    @(posedge mclk);
    trapVec <= m;
    @(posedge mclk);
    trapVec <= 4'h0;
    settle();
  endtask
  task automatic set_pins(input logic [4:0] p);
    @(posedge mclk);
    extPin <= p;
    settle();
  endtask
  task automatic load_prio(input logic [3:0] v);
    @(posedge mclk);
    cpuPrioLoad <= 1'b1;
    cpuPrioValue <= v;
    @(posedge mclk);
    cpuPrioLoad <= 1'b0;
    settle();
  endtask
  task automatic set_insn(input logic b);
    @(posedge mclk);
    disableInsnActive <= b;
  endtask
endmodule

// file: tb/tb.sv
/*
  Self-checking bench of the interrupt control and flag registers.
  Assumes an Avalon-MM slave with waitrequest.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import icf_pkg::*;
  logic        mclk = 1'b0;
  logic        rst_n, avsRead, avsWrite, avsWaitRequest;
  logic [5:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  logic [3:0]  avsByteEnable, cpuPrioValue, cpuPriority;
  logic [15:0] srcReq0, srcReq1, srcReq2, rdq;
  logic [4:0]  extPin, extEdgeEvent, edgeSeen;
  logic        trapArith, trapAddr, trapStack, trapOsc;
  logic        cpuPrioLoad, disableInsnActive, nestingDisable;
  logic        altTableSelect, cpuRequest, irqOut;
  int          errors = 0;
  int          total_checks = 0;
  localparam logic [15:0] FMASK [3] = '{MASK_FLAGS0, MASK_FLAGS1, MASK_FLAGS2};
  localparam logic [3:0]  LVL [3] = '{4'h6, 4'h7, 4'h8};
  localparam logic [15:0] REQ [3] = '{16'h0001, 16'h0000, 16'h0000};

  always #20 mclk = ~mclk;
  always @(posedge mclk) edgeSeen <= edgeSeen | extEdgeEvent;

  icf_regs u_icf_regs (.mclk, .rst_n, .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .srcReq0,
    .srcReq1, .srcReq2, .extPin, .trapArith, .trapAddr, .trapStack, .trapOsc,
    .cpuPrioLoad, .cpuPrioValue, .disableInsnActive, .cpuPriority,
    .nestingDisable, .altTableSelect, .extEdgeEvent, .cpuRequest, .irqOut);
  icf_src_model u_icf_src_model (.mclk, .srcReq0, .srcReq1, .srcReq2,
    .extPin, .trapArith, .trapAddr, .trapStack, .trapOsc, .cpuPrioLoad,
    .cpuPrioValue, .disableInsnActive);

  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus cycle, held until waitrequest low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge mclk);
    avsAddress <= a;
    avsWriteData <= {~d, d};
    avsWrite <= w;
    avsRead <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 20);
    if (avsWaitRequest !== 1'b0) begin
      errors++;
      results();
    end
    q = avsReadData[15:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    bus(1'b1, a, d, rdq);
  endtask
  task automatic rc(input string n, input logic [5:0] a, logic [15:0] e);
    bus(1'b0, a, 16'h0000, rdq);
    chk(n, rdq, e);
  endtask
  function automatic logic [5:0] fa(input int i);
    return OFF_FLAGS_BASE + 6'(4 * i);
  endfunction

  initial begin
    rst_n = 1'b0;
    avsAddress = 6'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h0000_0000;
    avsByteEnable = 4'hF;
    edgeSeen = 5'h00;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rc("core reset", OFF_CORE_PRIO, 16'h0004);
    rc("ctrl1 reset", OFF_CTRL_ONE, 16'h0000);
    rc("ctrl2 reset", OFF_CTRL_TWO, 16'h0000);
    rc("unmapped", 6'h3C, 16'h0000);
    avsByteEnable <= 4'h2;
    wr(OFF_CTRL_ONE, 16'h801E);
    rc("lane 1 only", OFF_CTRL_ONE, 16'h8000);
    avsByteEnable <= 4'hF;
    wr(OFF_CTRL_ONE, 16'hFFFF);
    rc("ctrl1 ones", OFF_CTRL_ONE, MASK_CTRL_ONE);
    chk("nestingDisable", 16'(nestingDisable), 16'h0001);
    wr(OFF_ALU_STATUS, 16'h00E0);
    rc("prio locked", OFF_ALU_STATUS, 16'h0000);
    wr(OFF_CTRL_ONE, 16'h0000);
    wr(OFF_ALU_STATUS, 16'h00E0);
    rc("prio", OFF_ALU_STATUS, 16'h00E0);
    chk("cpuPriority", 16'(cpuPriority), 16'h0007);
    for (int i = 0; i < 4; i++) begin
      u_icf_src_model.pulse_trap(4'(1 << i));
      rc("trap", OFF_CTRL_ONE, 16'(2 << i));
      wr(OFF_CTRL_ONE, 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      rc("flags reset", fa(i), 16'h0000);
      wr(fa(i), 16'hFFFF);
      rc("flags sw", fa(i), FMASK[i]);
      wr(fa(i), 16'h0000);
      u_icf_src_model.pulse_src(i, 16'hFFFF);
      repeat (8) @(posedge mclk);
      rc("flags hw", fa(i), FMASK[i]);
      wr(fa(i), 16'h0000);
      rc("flags clr", fa(i), 16'h0000);
    end
    wr(OFF_CTRL_TWO, 16'hFFFF);
    u_icf_src_model.set_insn(1'b1);
    rc("ctrl2 ones", OFF_CTRL_TWO, 16'hC01F);
    chk("altTableSelect", 16'(altTableSelect), 16'h0001);
    u_icf_src_model.set_pins(5'h1F);
    rc("rise ignored", fa(0), 16'h0000);
    u_icf_src_model.set_pins(5'h00);
    rc("fall ext0", fa(0), 16'h0001);
    rc("fall ext1 ext2", fa(1), 16'h2010);
    chk("edge events", 16'(edgeSeen), 16'h001F);
    wr(fa(0), 16'h0000);
    wr(fa(1), 16'h0000);
    wr(OFF_CTRL_TWO, 16'h0000);
    u_icf_src_model.set_insn(1'b0);
    u_icf_src_model.set_pins(5'h01);
    rc("rise ext0", fa(0), 16'h0001);
    u_icf_src_model.load_prio(4'hF);
    rc("core ext", OFF_CORE_PRIO, 16'h000C);
    wr(OFF_CORE_PRIO, 16'h0000);
    rc("ext clear", OFF_CORE_PRIO, 16'h0004);
    wr(OFF_CORE_PRIO, 16'h0008);
    rc("ext no set", OFF_CORE_PRIO, 16'h0004);
    wr(OFF_ENABLE_BASE, 16'h0001);
    wr(OFF_SRC_PRIO, 16'h0007);
    for (int i = 0; i < 3; i++) begin
      u_icf_src_model.load_prio(LVL[i]);
      chk("cpuRequest", 16'(cpuRequest), REQ[i]);
    end
    u_icf_src_model.load_prio(4'h0);
    wr(OFF_ENABLE_BASE, 16'h0000);
    repeat (2) @(posedge mclk);
    chk("cpuRequest off", 16'(cpuRequest), 16'h0000);
    wr(OFF_IRQ_MASK, 16'h0007);
    bus(1'b0, OFF_IRQ_STATUS, 16'h0000, rdq);
    u_icf_src_model.pulse_trap(4'h1);
    chk("irqOut", 16'(irqOut), 16'h0001);
    rc("irq status", OFF_IRQ_STATUS, 16'h0002);
    repeat (2) @(posedge mclk);
    chk("irqOut clr", 16'(irqOut), 16'h0000);
    wr(OFF_IRQ_MASK, 16'h0000);
    u_icf_src_model.pulse_trap(4'h1);
    chk("irqOut masked", 16'(irqOut), 16'h0000);
    results();
  end
endmodule
